//--- core/dtt_pkg.sv
// Purpose: Shared constants and carrier types for the dual interval timer.
// Assumes: APB slave with 32-bit data, word aligned registers.
// Notes:   Byte addresses below are low address bits of the APB window.
package dtt_pkg;

  localparam int unsigned NUM_TIMERS = 2;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADDR_W     = 16;

  localparam logic [ADDR_W-1:0] OFS_MODE   = 16'h6000;
  localparam logic [ADDR_W-1:0] OFS_RELOAD0 = 16'h6004;
  localparam logic [ADDR_W-1:0] OFS_RELOAD1 = 16'h6008;
  localparam logic [ADDR_W-1:0] OFS_COUNT0 = 16'h600c;
  localparam logic [ADDR_W-1:0] OFS_COUNT1 = 16'h6010;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 16'h6014;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 16'h6018;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 16'h601c;

  // Mode register: bit n selects toggle mode for timer n
  localparam int unsigned MODE_TOGGLE_POS = 0;
  // Enable register: bit n starts timer n
  localparam int unsigned ENABLE_POS      = 0;
  // Status and mask registers: bit n is the time-out event of timer n
  localparam int unsigned EVENT_POS       = 0;

  localparam logic [31:0] RST_MODE   = 32'h0000_0000;
  localparam logic [31:0] RST_RELOAD = 32'h0000_0000;
  localparam logic [31:0] RST_COUNT  = 32'hffff_ffff;
  localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_STATUS = 32'h0000_0000;
  localparam logic [31:0] RST_MASK   = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO  = 32'h0000_0000;

  // Bus access takes one wait state before pready
  localparam int unsigned APB_WAIT_CYCLES = 1;

  typedef struct packed {
    logic        enable;
    logic        toggle;
    logic [31:0] reload;
  } dtt_chan_cfg_type;

  typedef struct packed {
    logic        wr;
    logic [31:0] data;
  } dtt_cnt_wr_type;

endpackage

//--- core/dtt_channel.sv
// Purpose: One 32-bit down counter with interval and toggle output modes.
// Assumes: Config comes from registers on the same clock.
// Notes:   All outputs are flip-flops.
module dtt_channel
  import dtt_pkg::*;
(
  input  wire logic             pclk,     // System clock
  input  wire logic             presetn,  // Async reset, active low
  input  wire dtt_chan_cfg_type cfg,      // Enable, mode, reload value
  input  wire dtt_cnt_wr_type   cnt_wr,   // Software write to count
  output logic [31:0]           count_q,  // Current count
  output logic                  expire_q, // Time-out pulse, one cycle
  output logic                  out_q     // Timer output pin
);

  logic enable_q;
  logic toggle_q;
  logic start;
  logic expire;

  assign start  = cfg.enable && !enable_q;
  assign expire = cfg.enable && !start && (count_q == 32'h0000_0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= cfg.enable;
    end
  end

  // Software write wins over counting so a preset is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= RST_COUNT;
    end else if (cnt_wr.wr) begin
      count_q <= cnt_wr.data;
    end else if (start) begin
      count_q <= cfg.reload;
    end else if (expire) begin
      count_q <= cfg.reload;
    end else if (cfg.enable) begin
      count_q <= count_q - 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expire_q <= 1'b0;
    end else begin
      expire_q <= expire;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toggle_q <= 1'b0;
    end else if (expire) begin
      toggle_q <= !toggle_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 1'b0;
    end else if (cfg.toggle) begin
      out_q <= toggle_q ^ expire;
    end else begin
      out_q <= expire;
    end
  end

endmodule

//--- core/dtt_timer_top.sv
// Purpose: Two independent 32-bit timers behind an APB register slave.
// Assumes: Single clock; APB master follows APB3 signalling.
// Notes:   Every access sees one wait state; unmapped access sets pslverr.
//
// The APB interface to the registers was left to the implementer.

module dtt_timer_top
  import dtt_pkg::*;
#(
  parameter int unsigned TIMERS = NUM_TIMERS // Number of timers
)
(
  input  wire logic              pclk,          // System clock, 100 MHz
  input  wire logic              presetn,       // Async reset, active low
  input  wire logic [ADDR_W-1:0] paddr,         // APB byte address
  input  wire logic              psel,          // APB select
  input  wire logic              penable,       // APB access phase
  input  wire logic              pwrite,        // APB write when high
  input  wire logic [31:0]       pwdata,        // APB write data
  output logic [31:0]            prdata,        // APB read data
  output logic                   pready,        // APB ready
  output logic                   pslverr,       // APB error, unmapped
  output logic [TIMERS-1:0]      timer_n_output, // Timer output pins
  output logic [TIMERS-1:0]      timer_n_irq,   // Time-out pulses
  output logic                   irq            // Level interrupt
);

  // Register storage
  logic [31:0]       timer_mode_ctrl_q;
  logic [TIMERS-1:0] timer_enable_ctrl_q;
  logic [31:0]       reload_q [TIMERS];
  logic [TIMERS-1:0] irq_status_q;
  logic [TIMERS-1:0] irq_mask_q;

  // Bus handshake
  logic              access;
  logic              commit;
  logic              wr_commit;
  logic              hit;
  logic [31:0]       rdata;
  logic              wr_mode;
  logic              wr_enable;
  logic              wr_status;
  logic              wr_mask;
  logic              rd_fetch;
  logic              bad_access;

  // Per-timer wiring
  logic [31:0]       count [TIMERS];
  logic [TIMERS-1:0] expire;
  logic [TIMERS-1:0] tout;
  logic [TIMERS-1:0] reload_hit;
  logic [TIMERS-1:0] count_hit;
  logic [TIMERS-1:0] status_d;
  logic [TIMERS-1:0] wr_reload;
  logic [TIMERS-1:0] wr_count;
  logic [TIMERS-1:0] clr_status;

  dtt_chan_cfg_type  cfg [TIMERS];
  dtt_cnt_wr_type    cnt_wr [TIMERS];

  // Access phase, first cycle: answer is registered one edge later
  assign access    = psel && penable && !pready;
  // Effect happens only on the edge where pready is seen high
  assign commit    = psel && penable && pready;
  assign wr_commit = commit && pwrite && !pslverr;

  // One write strobe per target keeps every register on the same commit
  assign wr_mode    = wr_commit && (paddr == OFS_MODE);
  assign wr_enable  = wr_commit && (paddr == OFS_ENABLE);
  assign wr_status  = wr_commit && (paddr == OFS_STATUS);
  assign wr_mask    = wr_commit && (paddr == OFS_MASK);
  // Read data and error are decided in the first access cycle
  assign rd_fetch   = access && !pwrite && hit;
  assign bad_access = access && !hit;

  generate
    for (genvar n = 0; n < TIMERS; n++) begin : g_timer
      assign reload_hit[n] = (paddr == OFS_RELOAD0 +
                              ADDR_W'(4 * n));
      assign count_hit[n]  = (paddr == OFS_COUNT0 +
                              ADDR_W'(4 * n));
      assign wr_reload[n]  = wr_commit && reload_hit[n];
      assign wr_count[n]   = wr_commit && count_hit[n];
      assign clr_status[n] = wr_status && pwdata[EVENT_POS + n];

      assign cfg[n].enable = timer_enable_ctrl_q[n];
      assign cfg[n].toggle =
        timer_mode_ctrl_q[MODE_TOGGLE_POS + n];
      assign cfg[n].reload = reload_q[n];

      assign cnt_wr[n].wr   = wr_count[n];
      assign cnt_wr[n].data = pwdata;

      // Reload is plain storage; changing it mid-run takes effect at
      // the next expiry, which is why software should stop first
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          reload_q[n] <= RST_RELOAD;
        end else if (wr_reload[n]) begin
          reload_q[n] <= pwdata;
        end
      end

      // Disabling only freezes the count; no reload here
      dtt_channel u_channel (
        .pclk     (pclk),
        .presetn  (presetn),
        .cfg      (cfg[n]),
        .cnt_wr   (cnt_wr[n]),
        .count_q  (count[n]),
        .expire_q (expire[n]),
        .out_q    (tout[n])
      );

      // Set wins over a write-one-to-clear in the same cycle
      assign status_d[n] = expire[n] ||
        (irq_status_q[n] && !clr_status[n]);
    end
  endgenerate

  // Address decode
  always_comb begin
    hit = 1'b0;
    case (paddr)
      OFS_MODE,
      OFS_ENABLE,
      OFS_STATUS,
      OFS_MASK: begin
        hit = 1'b1;
      end
      default: begin
        hit = |reload_hit || |count_hit;
      end
    endcase
  end

  // Read mux, narrower fields sit in low bits
  always_comb begin
    rdata = READ_ZERO;
    case (paddr)
      OFS_MODE: begin
        rdata = timer_mode_ctrl_q;
      end
      OFS_ENABLE: begin
        rdata[ENABLE_POS +: TIMERS] = timer_enable_ctrl_q;
      end
      OFS_STATUS: begin
        rdata[EVENT_POS +: TIMERS] = irq_status_q;
      end
      OFS_MASK: begin
        rdata[EVENT_POS +: TIMERS] = irq_mask_q;
      end
      default: begin
        for (int i = 0; i < TIMERS; i++) begin
          if (reload_hit[i]) begin
            rdata = reload_q[i];
          end
          if (count_hit[i]) begin
            rdata = count[i];
          end
        end
      end
    endcase
  end

  // APB answer: pready rises one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= bad_access;
    end
  end

  // Read data is captured with pready so it stands for the sampling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= READ_ZERO;
    end else if (rd_fetch) begin
      prdata <= rdata;
    end else if (access) begin
      prdata <= READ_ZERO;
    end
  end

  // Mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_ctrl_q <= RST_MODE;
    end else if (wr_mode) begin
      timer_mode_ctrl_q <= pwdata;
    end
  end

  // Enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_enable_ctrl_q <= RST_ENABLE[TIMERS-1:0];
    end else if (wr_enable) begin
      timer_enable_ctrl_q <= pwdata[ENABLE_POS +: TIMERS];
    end
  end

  // Interrupt status, sticky
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= RST_STATUS[TIMERS-1:0];
    end else begin
      irq_status_q <= status_d;
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= RST_MASK[TIMERS-1:0];
    end else if (wr_mask) begin
      irq_mask_q <= pwdata[EVENT_POS +: TIMERS];
    end
  end

  // Level interrupt from next status so it is not a cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_d & irq_mask_q);
    end
  end

  // Output pins and raw request pulses, re-timed by one flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_n_output <= '0;
    end else begin
      timer_n_output <= tout;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_n_irq <= '0;
    end else begin
      timer_n_irq <= expire;
    end
  end

endmodule

//--- testbench/dtt_timer_chk.sv
// Purpose: Port checks for the dual timer bus slave and timer outputs.
// Assumes: The master holds each request until pready.
// Notes:   Mode bits must not change while a timer runs.
module dtt_timer_chk
  import dtt_pkg::*;
#(
  parameter int unsigned TIMERS = NUM_TIMERS // Timer count
)
(
  input wire logic              pclk,           // Clock
  input wire logic              presetn,        // Reset, low
  input wire logic [ADDR_W-1:0] paddr,          // Address
  input wire logic              psel,           // Select
  input wire logic              penable,        // Access
  input wire logic              pwrite,         // Write
  input wire logic [31:0]       pwdata,         // Write data
  input wire logic [31:0]       prdata,         // Read data
  input wire logic              pready,         // Ready
  input wire logic              pslverr,        // Error
  input wire logic [TIMERS-1:0] timer_n_output, // Pins
  input wire logic [TIMERS-1:0] timer_n_irq,    // Pulses
  input wire logic              irq             // Level
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  // Map is 0x6000 to 0x601c, word aligned
  assign mapped = paddr[15:5] == 11'h300 && paddr[1:0] == 2'b00;
  rdy_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("pready too long");
  rdy_phase_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  err_map_a: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  err_read_a: assert property (pready && pslverr && !pwrite |-> prdata == 0)
    else $error("unmapped read not zero");
  rst_out_a: assert property ($rose(presetn) |-> timer_n_output == 0 && !irq)
    else $error("outputs not low after reset");
  out_irq_a: assert property
    (timer_n_irq[0] |-> timer_n_output[0] || $changed(timer_n_output[0]))
    else $error("request without output event");
  tog_src_a: assert property
    ($changed(timer_n_output[1]) |-> timer_n_irq[1] || $fell(timer_n_irq[1]))
    else $error("output moved without time-out");
endmodule

bind dtt_timer_top dtt_timer_chk #(.TIMERS(TIMERS)) i_dtt_timer_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_n_output(timer_n_output),
  .timer_n_irq(timer_n_irq), .irq(irq));

//--- testbench/tb.sv
// Purpose: Self-checking bench for the dual timer.
// Assumes: Bus results come back in request order.
// Notes:   Bus answers are checked from a queue of expectations.
module tb
  import dtt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
    bad_count++; $display("wrong value at %0t: %h want %h", $time, a, b); \
  end end
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [1:0]        timer_n_output;
  logic [1:0]        timer_n_irq;
  logic              irq;
  logic [31:0]       seed = 32'haff6_90a7;
  logic [33:0]       exp_q[$];
  int                bad_count = 0;
  int                check_count = 0;
  int                cyc = 0;

  dtt_timer_top i_dtt_timer_top (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_n_output(timer_n_output),
    .timer_n_irq(timer_n_irq), .irq(irq));

  initial forever #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  // Reads before the edge's updates land, so values are the sampled ones
  always @(posedge pclk) begin
    if (pready === 1'b1 && exp_q.size() > 0) begin
      `CHK(pslverr, exp_q[0][32])
      if (exp_q[0][33]) `CHK(prdata, exp_q[0][31:0])
      void'(exp_q.pop_front());
    end
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic test_done();
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Entry: bit 33 compares data, bit 32 is the expected error
  task automatic apb(input logic [15:0] a, input logic w,
                     input logic [31:0] d, input logic [33:0] e,
                     output logic [31:0] r);
    exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only pready or the bench timeout ends this wait
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(a, 1'b1, d, 34'h0, r);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] x);
    logic [31:0] r;
    apb(a, 1'b0, '0, {2'b10, x}, r);
  endtask

  task automatic seek(input int n);
    for (int k = 0; k < 200 && timer_n_irq[n] !== 1'b0; k++) @(posedge pclk);
    for (int k = 0; k < 200 && timer_n_irq[n] !== 1'b1; k++) @(posedge pclk);
  endtask

  task automatic period(input int n, input logic [31:0] rl, input logic tg);
    int   t0;
    logic o;
    seek(n);
    t0 = cyc;
    o = timer_n_output[n];
    seek(n);
    `CHK(cyc - t0, int'(rl) + 1)
    `CHK(timer_n_output[n], tg ? ~o : 1'b1)
  endtask

  initial begin
    logic [15:0] ra [5];
    logic [31:0] v;
    logic [31:0] r0;
    logic [31:0] r1;
    logic [31:0] c;
    ra = '{OFS_MODE, OFS_RELOAD0, OFS_RELOAD1, OFS_COUNT0, OFS_COUNT1};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(timer_n_output, 2'b00)
    rd(OFS_MODE, RST_MODE);
    rd(OFS_RELOAD0, RST_RELOAD);
    rd(OFS_RELOAD1, RST_RELOAD);
    rd(OFS_COUNT0, RST_COUNT);
    rd(OFS_COUNT1, RST_COUNT);
    rd(OFS_ENABLE, RST_ENABLE);
    rd(OFS_STATUS, RST_STATUS);
    rd(OFS_MASK, RST_MASK);
    foreach (ra[i]) begin
      v = rnd();
      wr(ra[i], v);
      rd(ra[i], v);
    end
    v = rnd();
    apb(16'h6020, 1'b1, v, {2'b01, 32'h0}, c);
    apb(16'h6020, 1'b0, '0, {2'b11, 32'h0}, c);
    r0 = {29'h0, v[2:0]} + 32'h1;
    r1 = {29'h0, v[5:3]} + 32'h1;
    wr(OFS_MODE, 32'h0000_0002);
    wr(OFS_RELOAD0, r0);
    wr(OFS_RELOAD1, r1);
    wr(OFS_ENABLE, 32'h0000_0003);
    period(0, r0, 1'b0);
    period(1, r1, 1'b1);
    `CHK(irq, 1'b0)
    wr(OFS_ENABLE, 32'h0);
    apb(OFS_COUNT0, 1'b0, '0, 34'h0, c);
    repeat (3) @(posedge pclk);
    rd(OFS_COUNT0, c);
    rd(OFS_STATUS, 32'h0000_0003);
    wr(OFS_MASK, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b1)
    wr(OFS_STATUS, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    rd(OFS_STATUS, 32'h0000_0002);
    wr(OFS_RELOAD0, 32'h0000_0100);
    wr(OFS_ENABLE, 32'h0000_0001);
    wr(OFS_ENABLE, 32'h0);
    apb(OFS_COUNT0, 1'b0, '0, 34'h0, c);
    // Loaded one edge after enable, then three decrements up to disable
    `CHK(c, 32'h0000_00fd)
    test_done();
  end
endmodule
